// ===== hdl/opd_decoder.sv
// Purpose: Captures operand bytes of one instruction and decodes source and destination.
// Assumes: Program memory presents one byte per cycle with byte_valid; opcode sets kinds and order.
// Notes: A new instruction starts with start; decoded outputs are registered.
// Notes on behaviour
// [RULE1] Operand bytes come source first unless the opcode selects the other order.
// [RULE2] A plain register byte reaches any location 0 to 255.
// [RULE3] A byte with upper nibble E selects working register by its low nibble.
// [RULE4] Bit number is three bits, position 0 to 7.
// [RULE5] Direct address is a full 16-bit program address.
// [RULE6] Extended register operand is a 12-bit register address.
// [RULE7] Immediate operand is one literal byte, 00 to FF.
// [RULE8] Working pair selects only even pairs 0 to 14.
// [RULE9] Full pair addresses only even locations 00 to FE.
// [RULE10] Relative displacement is signed, added to next instruction address.
// [RULE11] Indexed location is register plus signed byte index.
// [RULE12] Polarity is one bit choosing zero or one.
// [RULE13] Trap vector is an 8-bit value 00 to FF.
// [RULE14] Add writes source plus destination back to the destination.
`timescale 1ns/1ps
module opd_decoder
  import opd_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic start, // Pulse: new instruction, clears captured bytes.
  input wire opd_pkg::opd_order_e order, // Object code byte order for this opcode.
  input wire opd_pkg::opd_kind_e src_kind, // Source operand kind.
  input wire opd_pkg::opd_kind_e dst_kind, // Destination operand kind.
  input wire logic [1:0] byte_count, // Operand bytes expected, 1 to 3.
  input wire logic byte_valid, // Operand byte present.
  input wire logic [7:0] byte_in, // Operand byte from program memory.
  input wire logic [7:0] reg_ptr, // Working register group pointer.
  input wire logic [15:0] next_pc, // Address of the following instruction.
  input wire logic [7:0] src_data, // Source value read from register file.
  input wire logic [7:0] dst_data, // Destination value read from register file.
  input wire logic add_en, // Operation is an add.
  output logic done, // Pulse: operand bytes captured; decoded outputs follow one cycle later.
  output logic [15:0] src_out, // Decoded source address or value.
  output logic [15:0] dst_out, // Decoded destination address or value.
  output logic [15:0] target_out, // Relative or indexed effective address.
  output logic wr_en, // Pulse: write result to destination.
  output logic [11:0] wr_addr, // Destination write address.
  output logic [7:0] wr_data // Sum written back.
);
  import opd_pkg::*;

  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [1:0] cnt;
    logic busy;
    logic done;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] tgt;
    logic wr;
    logic [11:0] waddr;
    logic [7:0] wdata;
  } opd_state_s;

  opd_state_s st_ff;
  opd_state_s nxt_st;
  logic [15:0] src_map;
  logic [15:0] dst_map;
  logic [7:0] src_a;
  logic [7:0] dst_a;
  logic [7:0] dst_b;
  logic last;

  // Source-first order puts the source in byte 0 and destination after it.
  always_comb begin
    if (order == OPD_ORD_SRC_DST) begin
      src_a = st_ff.b0; // RULE1
      dst_a = st_ff.b1;
      dst_b = st_ff.b2;
    end else begin
      dst_a = st_ff.b0; // RULE1
      dst_b = st_ff.b1;
      src_a = st_ff.b2;
    end
  end

  opd_field_map u_src (
    .kind(src_kind),
    .byte_a(src_a),
    .byte_b(st_ff.b2),
    .reg_ptr(reg_ptr),
    .value(src_map)
  );

  opd_field_map u_dst (
    .kind(dst_kind),
    .byte_a(dst_a),
    .byte_b(dst_b),
    .reg_ptr(reg_ptr),
    .value(dst_map)
  );

  // A byte count of zero is not legal; it ends the instruction on its first byte.
  // Counting stops at three bytes, so a longer count would never finish.
  assign last = st_ff.busy && byte_valid && (st_ff.cnt + 2'h1 >= byte_count);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.wr = 1'b0;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = 2'h0;
      nxt_st.b0 = OPD_RST_BYTE;
      nxt_st.b1 = OPD_RST_BYTE;
      nxt_st.b2 = OPD_RST_BYTE;
    end else if (st_ff.busy && byte_valid) begin
      unique case (st_ff.cnt)
        2'h0: nxt_st.b0 = byte_in;
        2'h1: nxt_st.b1 = byte_in;
        default: nxt_st.b2 = byte_in;
      endcase
      nxt_st.cnt = st_ff.cnt + 2'h1;
      if (last) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
    // Decoding happens one cycle after the last byte so all bytes are settled.
    if (st_ff.done) begin
      nxt_st.src = src_map;
      nxt_st.dst = dst_map;
      if (src_kind == OPD_K_REL) begin
        nxt_st.tgt = next_pc + src_map; // RULE10
      end else if (src_kind == OPD_K_IDX) begin
        nxt_st.tgt = dst_map + src_map; // RULE11
      end else begin
        nxt_st.tgt = OPD_RST_ADDR;
      end
      // Operand values are read back in the same cycle from the register file.
      if (add_en) begin
        nxt_st.wr = 1'b1;
        nxt_st.waddr = dst_map[11:0]; // RULE14
        nxt_st.wdata = src_data + dst_data; // RULE14
      end
    end
    if (!rst_n) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign done = st_ff.done;
  assign src_out = st_ff.src;
  assign dst_out = st_ff.dst;
  assign target_out = st_ff.tgt;
  assign wr_en = st_ff.wr;
  assign wr_addr = st_ff.waddr;
  assign wr_data = st_ff.wdata;

  a_add_writeback: assert property (@(posedge mclk) disable iff (!rst_n) // RULE14
    $rose(st_ff.done) && add_en |=> wr_en && wr_data == $past(src_data) + $past(dst_data))
    else $error("add result not written back");
  a_rel_target: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    st_ff.done && src_kind == OPD_K_REL |=> target_out == $past(next_pc) + $past(src_map))
    else $error("relative target wrong");
  a_idx_target: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
    st_ff.done && src_kind == OPD_K_IDX |=> target_out == $past(dst_map) + $past(src_map))
    else $error("indexed target wrong");
  a_wpair_even: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    dst_kind == OPD_K_WPAIR |-> dst_map[0] == 1'b0)
    else $error("working pair odd");
  a_fpair_even: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    dst_kind == OPD_K_FPAIR |-> dst_map[15:8] == 8'h00 && dst_map[0] == 1'b0)
    else $error("full pair odd");
  a_escape_wreg: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    src_kind == OPD_K_REG && src_a[7:4] == OPD_ESC_NIBBLE |-> src_map[3:0] == src_a[3:0]
    && src_map[11:4] == reg_ptr)
    else $error("escaped register wrong");
  a_ext_range: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
    dst_kind == OPD_K_EXT |-> dst_map[15:12] == 4'h0)
    else $error("extended address too wide");
  a_done_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    done |=> !done)
    else $error("done longer than one cycle");
  a_da_full: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    dst_kind == OPD_K_DA |-> dst_map == {dst_a, dst_b})
    else $error("direct address wrong");
  // Reset must leave no stale write strobe behind, or a half-decoded add could land after it.
  a_reset_quiet: assert property (@(posedge mclk) // RULE14
    !rst_n |=> !done && !wr_en && src_out == 16'h0000 && dst_out == 16'h0000)
    else $error("outputs not cleared by reset");
  a_wr_after_done: assert property (@(posedge mclk) disable iff (!rst_n) // RULE14
    wr_en |-> $past(st_ff.done) && $past(add_en))
    else $error("write back without a decoded add");
  a_plain_reg: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    src_kind == OPD_K_REG && src_a[7:4] != OPD_ESC_NIBBLE |-> src_map == {8'h00, src_a})
    else $error("plain register wrong");
  a_imm_byte: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
    src_kind == OPD_K_IMM |-> src_map == {8'h00, src_a})
    else $error("immediate byte wrong");
  a_vec_byte: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
    src_kind == OPD_K_VEC |-> src_map == {8'h00, src_a})
    else $error("trap vector wrong");
  a_bit_number: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
    src_kind == OPD_K_BIT |-> src_map[15:4] == 12'h000 && src_map[2:0] == src_a[2:0])
    else $error("bit number wrong");
  a_polarity_bit: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
    src_kind == OPD_K_BIT |-> src_map[3] == src_a[OPD_POL_POS])
    else $error("polarity bit wrong");
  a_wreg_group: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    dst_kind == OPD_K_WREG |-> dst_map == {4'h0, reg_ptr, dst_a[3:0]})
    else $error("working register wrong");
  a_order_swap: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    order == OPD_ORD_DST_SRC |-> dst_a == st_ff.b0 && dst_b == st_ff.b1 && src_a == st_ff.b2)
    else $error("destination first order wrong");

  c_add: cover property (@(posedge mclk) wr_en);
  c_rel: cover property (@(posedge mclk) done && src_kind == OPD_K_REL);
  c_dst_first: cover property (@(posedge mclk) done && order == OPD_ORD_DST_SRC);
  c_wpair: cover property (@(posedge mclk) done && dst_kind == OPD_K_WPAIR);
  c_ext: cover property (@(posedge mclk) done && dst_kind == OPD_K_EXT);
endmodule // opd_decoder

// ===== inc/opd_pkg.sv
// Purpose: Shared constants and types for the operand field decoder.
// Assumes: Byte-wide instruction stream, 12-bit register file address space.
// Notes: Escaped working registers are relocated by the register pointer.
package opd_pkg;
  localparam logic [3:0] OPD_ESC_NIBBLE = 4'he;
  localparam logic [7:0] OPD_RST_BYTE = 8'h00;
  localparam logic [15:0] OPD_RST_ADDR = 16'h0000;
  localparam int OPD_POL_POS = 3;
  localparam int OPD_BIT_LSB = 0;
  localparam logic [3:0] OPD_PAIR_MASK = 4'he;
  localparam logic [7:0] OPD_FPAIR_MASK = 8'hfe;

  // Operand kinds; codes 4'h8, 4'h9 and 4'hb are unused and decode as a zero-extended byte, with no E-nibble escape.
  typedef enum logic [3:0] {
    OPD_K_REG = 4'h0,
    OPD_K_WREG = 4'h1,
    OPD_K_IND_WREG = 4'h3,
    OPD_K_IND_REG = 4'h2,
    OPD_K_WPAIR = 4'h6,
    OPD_K_FPAIR = 4'h7,
    OPD_K_EXT = 4'h5,
    OPD_K_IMM = 4'h4,
    OPD_K_BIT = 4'hc,
    OPD_K_REL = 4'hd,
    OPD_K_IDX = 4'hf,
    OPD_K_VEC = 4'he,
    OPD_K_DA = 4'ha
  } opd_kind_e;

  // Byte order choice per opcode.
  typedef enum logic {
    OPD_ORD_SRC_DST = 1'b0,
    OPD_ORD_DST_SRC = 1'b1
  } opd_order_e;
endpackage

// ===== hdl/opd_field_map.sv
// Purpose: Maps one operand byte (or byte pair) to a register file address or value.
// Assumes: Combinational; register pointer supplies the working register group.
// Notes: Used once per operand slot by the decoder.
`timescale 1ns/1ps
module opd_field_map
  import opd_pkg::*;
(
  input wire opd_pkg::opd_kind_e kind, // Operand kind.
  input wire logic [7:0] byte_a, // First operand byte.
  input wire logic [7:0] byte_b, // Second byte, used by wide kinds.
  input wire logic [7:0] reg_ptr, // Working register group pointer.
  output logic [15:0] value // Decoded address or value.
);
  import opd_pkg::*;

  always_comb begin
    value = {8'h00, byte_a};
    unique case (kind)
      OPD_K_REG, OPD_K_IND_REG: begin
        if (byte_a[7:4] == OPD_ESC_NIBBLE) begin
          value = {4'h0, reg_ptr, byte_a[3:0]}; // RULE3
        end else begin
          value = {8'h00, byte_a}; // RULE2
        end
      end
      OPD_K_WREG, OPD_K_IND_WREG: value = {4'h0, reg_ptr, byte_a[3:0]}; // RULE3
      OPD_K_WPAIR: value = {4'h0, reg_ptr, byte_a[3:0] & OPD_PAIR_MASK}; // RULE8
      OPD_K_FPAIR: value = {8'h00, byte_a & OPD_FPAIR_MASK}; // RULE9
      OPD_K_EXT: value = {4'h0, byte_a[3:0], byte_b}; // RULE6
      OPD_K_IMM: value = {8'h00, byte_a}; // RULE7
      OPD_K_VEC: value = {8'h00, byte_a}; // RULE13
      OPD_K_DA: value = {byte_a, byte_b}; // RULE5
      OPD_K_BIT: value = {12'h000, byte_a[OPD_POL_POS], byte_a[OPD_BIT_LSB +: 3]}; // RULE4 RULE12
      OPD_K_REL, OPD_K_IDX: value = {{8{byte_a[7]}}, byte_a};
      // Codes with no kind assigned fall back to a plain register byte rather than an unknown address.
      default: value = {8'h00, byte_a};
    endcase
  end
endmodule // opd_field_map

// ===== sim/opd_prog_mem.sv
// Purpose: Program memory model feeding operand bytes to the decoder.
// Assumes: go comes with start; bytes follow from the next edge on.
// Notes: slow inserts an idle cycle after every byte.
`timescale 1ns/1ps
module opd_prog_mem (
  input wire logic mclk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic go, // Load a new byte image.
  input wire logic slow, // Stall between bytes.
  input wire logic [23:0] img, // Bytes, first in the top byte.
  input wire logic [1:0] cnt, // Bytes to send.
  output logic byte_valid, // Byte present.
  output logic [7:0] byte_in // Byte value.
);
  logic [23:0] sh;
  logic [1:0] left;
  always @(posedge mclk) begin
    if (!rst_n) begin
      byte_valid <= 1'b0;
      byte_in <= 8'h00;
      left <= 2'h0;
    end else if (go) begin
      byte_valid <= 1'b1;
      byte_in <= img[23:16];
      sh <= img << 8;
      left <= cnt - 2'h1;
    end else if (left != 2'h0 && !(slow && byte_valid)) begin
      byte_valid <= 1'b1;
      byte_in <= sh[23:16];
      sh <= sh << 8;
      left <= left - 2'h1;
    end else begin
      // An idle bus must not look like a repeat of the last byte.
      byte_valid <= 1'b0;
      byte_in <= ~byte_in;
    end
  end
endmodule // opd_prog_mem

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the operand decoder.
// Assumes: Register pointer 12 and next address 0100 until the mid-run reset test changes them.
// Notes: Rows hold kinds, bytes and expected src, dst, target.
`timescale 1ns/1ps
module tb_top;
  import opd_pkg::*;
  typedef struct packed {opd_order_e o; opd_kind_e sk; opd_kind_e dk; logic [1:0] n; logic [23:0] img;
    logic [47:0] ex; logic [2:0] m;} opd_row_s;
  logic mclk = 0, rst_n = 0, start = 0, go = 0, slow = 0, add_en = 0, byte_valid, done, wr_en;
  opd_order_e order = OPD_ORD_SRC_DST;
  opd_kind_e src_kind = OPD_K_REG, dst_kind = OPD_K_REG;
  logic [1:0] byte_count = 2'h1;
  logic [23:0] img = 24'h0;
  logic [7:0] byte_in, reg_ptr = 8'h12, src_data = 8'h7f, dst_data = 8'h81, wr_data;
  logic [15:0] next_pc = 16'h0100, src_out, dst_out, target_out;
  logic [11:0] wr_addr;
  int err_total = 0, n_checks = 0, cyc = 0;
  opd_row_s rows[12];
  always #25 mclk = ~mclk;
  opd_decoder dut (.mclk(mclk), .rst_n(rst_n), .start(start), .order(order), .src_kind(src_kind),
    .dst_kind(dst_kind), .byte_count(byte_count), .byte_valid(byte_valid), .byte_in(byte_in),
    .reg_ptr(reg_ptr), .next_pc(next_pc), .src_data(src_data), .dst_data(dst_data), .add_en(add_en),
    .done(done), .src_out(src_out), .dst_out(dst_out), .target_out(target_out), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data));
  opd_prog_mem pm (.mclk(mclk), .rst_n(rst_n), .go(go), .slow(slow), .img(img), .cnt(byte_count),
    .byte_valid(byte_valid), .byte_in(byte_in));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task run(input opd_row_s r, input logic a);
    int k;
    @(posedge mclk);
    order <= r.o; src_kind <= r.sk; dst_kind <= r.dk; byte_count <= r.n; img <= r.img;
    start <= 1'b1; go <= 1'b1; add_en <= a; slow <= a;
    @(posedge mclk);
    start <= 1'b0; go <= 1'b0;
    for (k = 0; k < 12 && done !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    chk("done", 16'h1, {15'h0, done});
    @(posedge mclk);
    #1;
    chk("wr_en", {15'h0, a}, {15'h0, wr_en});
  endtask
  initial begin
    rows[0] = '{OPD_ORD_SRC_DST, OPD_K_REG, OPD_K_REG, 2'h2, 24'h084300, 48'h0008_0043_0000, 3'b110};
    rows[1] = '{OPD_ORD_SRC_DST, OPD_K_REG, OPD_K_REG, 2'h2, 24'he84300, 48'h0128_0043_0000, 3'b110};
    rows[2] = '{OPD_ORD_SRC_DST, OPD_K_IMM, OPD_K_DA, 2'h3, 24'hffbeef, 48'h00ff_beef_0000, 3'b110};
    rows[3] = '{OPD_ORD_DST_SRC, OPD_K_REG, OPD_K_DA, 2'h3, 24'h1234ff, 48'h00ff_1234_0000, 3'b110};
    rows[4] = '{OPD_ORD_SRC_DST, OPD_K_IMM, OPD_K_EXT, 2'h3, 24'h000fff, 48'h0000_0fff_0000, 3'b110};
    rows[5] = '{OPD_ORD_SRC_DST, OPD_K_BIT, OPD_K_REG, 2'h2, 24'h0f8000, 48'h000f_0080_0000, 3'b110};
    rows[6] = '{OPD_ORD_SRC_DST, OPD_K_REL, OPD_K_REG, 2'h1, 24'h800000, 48'hff80_0000_0080, 3'b101};
    rows[7] = '{OPD_ORD_SRC_DST, OPD_K_VEC, OPD_K_REG, 2'h1, 24'hff0000, 48'h00ff_0000_0000, 3'b100};
    rows[8] = '{OPD_ORD_SRC_DST, OPD_K_IDX, OPD_K_REG, 2'h2, 24'h804300, 48'hff80_0043_ffc3, 3'b111};
    rows[9] = '{OPD_ORD_SRC_DST, OPD_K_WREG, OPD_K_WPAIR, 2'h2, 24'h070a00, 48'h0127_012a_0000, 3'b110};
    rows[10] = '{OPD_ORD_SRC_DST, OPD_K_IND_REG, OPD_K_FPAIR, 2'h2, 24'he34400, 48'h0123_0044_0000, 3'b110};
    rows[11] = '{OPD_ORD_DST_SRC, OPD_K_IND_WREG, OPD_K_WREG, 2'h3, 24'h0500e9, 48'h0129_0125_0000, 3'b110};
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("src_out", 16'h0, src_out);
    chk("done", 16'h0, {15'h0, done});
    foreach (rows[i]) begin
      run(rows[i], 1'b0);
      if (rows[i].m[2]) chk("src_out", rows[i].ex[47:32], src_out);
      if (rows[i].m[1]) chk("dst_out", rows[i].ex[31:16], dst_out);
      if (rows[i].m[0]) chk("target_out", rows[i].ex[15:0], target_out);
    end
    // Slow memory and an add together: 7f plus 81 wraps to 00 in location 43.
    run(rows[0], 1'b1);
    chk("wr_addr", 16'h0043, {4'h0, wr_addr});
    chk("wr_data", 16'h0000, {8'h00, wr_data});
    // A reset in mid-instruction drops it and clears every output; then a new pointer and next address.
    @(posedge mclk);
    src_kind <= OPD_K_IMM;
    dst_kind <= OPD_K_REG;
    byte_count <= 2'h2;
    img <= 24'h5a6600;
    start <= 1'b1;
    go <= 1'b1;
    slow <= 1'b0;
    @(posedge mclk);
    start <= 1'b0;
    go <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("done", 16'h0, {15'h0, done});
    chk("wr_en", 16'h0, {15'h0, wr_en});
    chk("src_out", 16'h0, src_out);
    chk("dst_out", 16'h0, dst_out);
    chk("wr_addr", 16'h0, {4'h0, wr_addr});
    @(posedge mclk);
    rst_n <= 1'b1;
    reg_ptr <= 8'h3c;
    next_pc <= 16'h1000;
    run(rows[6], 1'b0);
    chk("target_out", 16'h0f80, target_out);
    run(rows[1], 1'b0);
    chk("src_out", 16'h03c8, src_out);
    end_sim;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim;
    end
  end
endmodule // tb_top
